/* File: fb_err_flags.sv */
// Fieldbus communications error flags with AXI4-Lite register access
// What this block does
// - On an error, halt exchange with the offending slave or with all slaves.
// - Halt of one slave sets non-fatal flag; halt of all sets fatal flag.
// - Each error also sets its cause flag and, for node 1 to 80, its node bit in the table.
// - Stored configuration disagreeing with found slaves sets the verification flag.
// - Too many slaves or bad topology sets the unsupported configuration flag.
// - Any exchange error sets the general process data error flag.
// - Count missed frames; beyond the configured count, set the reception timeout flag.
// - A failed check of stored communication parameters sets the parameter flag.
// - A frame that cannot be sent normally sets the send timing flag.
// - An error while establishing a slave link sets the link-down flag.
// - Two slaves sharing one node address set the duplicate address flag.
// - An error in slave initialization sets the initialization flag.
// - A slave reporting application-layer status error sets the status flag.
// - One error flag per node number, set on an error at that node.
// - Node flags 17 to 80 sit in a separate remote status area.
// - In stop mode every error halts all slaves and sets the fatal flag.
// - In continue mode the kind of error selects one slave or all.
module fb_err_flags
  import fb_err_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire fb_evt_t fb_evt,
  input wire logic cycle_tick,
  input wire logic frame_ok,
  input wire logic [NUM_CAUSE-1:0] cause_present,
  input wire logic [NODES-1:0] node_fault,
  output logic halt_all,
  output logic [NODES-1:0] halt_node,
  output logic irq
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [IRQ_W-1:0] flags;
    logic [NODES-1:0] nodes;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic halt_all;
    logic [NODES-1:0] halt_node;
  } st_t;

  st_t s;
  st_t n;
  logic tmo_pulse;
  logic err_rst;
  logic rd_stat;
  logic all_stop;
  logic [31:0] wm;
  logic [IRQ_W-1:0] setv;
  logic [NODE_W-1:0] idx;
  fb_evt_t evs [2];

  fb_rx_timeout u_tmo (
    .clk_sys(clk_sys),
    .rst(rst),
    .cycle_tick(cycle_tick),
    .frame_ok(frame_ok),
    .limit(s.ctrl[CTRL_TO_LSB +: TO_W]),
    .timeout(tmo_pulse)
  );

  always_comb begin
    n = s;
    err_rst = 1'b0;
    rd_stat = 1'b0;
    all_stop = 1'b0;
    setv = '0;
    idx = '0;
    evs[0] = fb_evt;
    evs[1] = '{valid: tmo_pulse, cause: C_TIMEOUT, node: 7'h00};
    for (int b = 0; b < 4; b++) begin
      wm[b*8 +: 8] = {8{s.wstrb[b]}};
    end

    // Write address and data, taken in either order
    if (s_axi_awvalid && s.awready) begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // Write execution once both halves are held
    if (s.aw_have && s.w_have && !s.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (s.awaddr)
        ADDR_CTRL: begin
          n.ctrl = ((s.ctrl & ~wm) | (s.wdata & wm)) & CTRL_WMASK;
          err_rst = s.wdata[CTRL_RESET_BIT] && s.wstrb[0];
        end
        ADDR_IRQ_MASK: begin
          n.irq_mask = (s.irq_mask & ~wm[IRQ_W-1:0]) | (s.wdata[IRQ_W-1:0] & wm[IRQ_W-1:0]);
        end
        ADDR_FLAGS, ADDR_IRQ_STAT, ADDR_REMOTE_LO, ADDR_REMOTE_HI, ADDR_HALT: begin
          n.bresp = RESP_OKAY;
        end
        default: begin
          n.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      case (s_axi_araddr)
        ADDR_CTRL: begin
          n.rdata = s.ctrl;
        end
        ADDR_FLAGS: begin
          n.rdata[IRQ_W-1:0] = s.flags;
          n.rdata[FLG_LOCAL_LSB +: LOCAL_NODES] = s.nodes[LOCAL_NODES-1:0];
        end
        ADDR_IRQ_STAT: begin
          n.rdata[IRQ_W-1:0] = s.irq_stat;
          rd_stat = 1'b1;
        end
        ADDR_IRQ_MASK: begin
          n.rdata[IRQ_W-1:0] = s.irq_mask;
        end
        ADDR_REMOTE_LO: begin
          n.rdata = s.nodes[LOCAL_NODES +: 32];
        end
        ADDR_REMOTE_HI: begin
          n.rdata = s.nodes[NODES-1 -: 32];
        end
        ADDR_HALT: begin
          n.rdata[HALT_ALL_BIT] = s.halt_all;
        end
        default: begin
          n.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Error reset keeps only flags whose cause is still present
    if (err_rst) begin
      n.flags[NUM_CAUSE-1:0] = s.flags[NUM_CAUSE-1:0] & cause_present;
      n.nodes = s.nodes & node_fault;
      n.halt_node = s.halt_node & node_fault;
      if (cause_present == '0 && node_fault == '0) begin
        n.flags[FLG_GENERAL] = 1'b0;
        n.flags[FLG_NONFATAL] = 1'b0;
        n.flags[FLG_FATAL] = 1'b0;
        n.halt_all = 1'b0;
      end
    end
    if (rd_stat) begin
      n.irq_stat = '0;
    end

    // Error events; a set in the same cycle beats any clear
    for (int i = 0; i < 2; i++) begin
      if (evs[i].valid) begin
        all_stop = s.ctrl[CTRL_STOP_BIT] || FATAL_KIND[evs[i].cause];
        setv = '0;
        setv[evs[i].cause] = 1'b1;
        setv[FLG_GENERAL] = 1'b1;
        if (all_stop) begin
          setv[FLG_FATAL] = 1'b1;
          n.halt_all = 1'b1;
        end else begin
          setv[FLG_NONFATAL] = 1'b1;
        end
        if (evs[i].node != 7'h00 && evs[i].node <= 7'h50) begin
          idx = evs[i].node - 7'h01;
          n.nodes[idx] = 1'b1;
          if (!all_stop) begin
            n.halt_node[idx] = 1'b1;
          end
        end
        n.flags = n.flags | setv;
        n.irq_stat = n.irq_stat | setv;
      end
    end

    n.irq = |(n.irq_stat & n.irq_mask);
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;
    n.arready = !n.rvalid;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign halt_all = s.halt_all;
  assign halt_node = s.halt_node;
  assign irq = s.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_stop_mode;
    fb_evt.valid && s.ctrl[CTRL_STOP_BIT] |=> s.flags[FLG_FATAL] && s.halt_all;
  endproperty
  a_stop_mode: assert property (p_stop_mode) else $error("stop mode error did not halt all");

  property p_fatal_kind;
    fb_evt.valid && FATAL_KIND[fb_evt.cause] |=> s.halt_all && s.flags[FLG_FATAL];
  endproperty
  a_fatal_kind: assert property (p_fatal_kind) else $error("fatal kind did not halt all");

  property p_nonfatal;
    fb_evt.valid && !s.ctrl[CTRL_STOP_BIT] && !FATAL_KIND[fb_evt.cause]
      && fb_evt.node == 7'h05 |=> s.flags[FLG_NONFATAL] && s.halt_node[4];
  endproperty
  a_nonfatal: assert property (p_nonfatal) else $error("single slave halt not flagged");

  property p_cause_flag;
    fb_evt.valid |=> s.flags[$past(fb_evt.cause)] && s.irq_stat[$past(fb_evt.cause)];
  endproperty
  a_cause_flag: assert property (p_cause_flag) else $error("cause flag not set");

  property p_node_bit;
    fb_evt.valid && fb_evt.node == 7'h50 |=> s.nodes[NODES-1];
  endproperty
  a_node_bit: assert property (p_node_bit) else $error("node table bit not set");

  property p_general;
    fb_evt.valid || tmo_pulse |=> s.flags[FLG_GENERAL];
  endproperty
  a_general: assert property (p_general) else $error("general error flag not set");

  property p_timeout;
    tmo_pulse |=> s.flags[C_TIMEOUT] && s.flags[FLG_FATAL];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flag not set");

  property p_sticky;
    !err_rst |=> (s.flags & $past(s.flags)) == $past(s.flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag dropped without reset");

  property p_irq_level;
    s.irq_stat[FLG_FATAL] && s.irq_mask[FLG_FATAL] |-> s.irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("unmasked status without interrupt");

  property p_bvalid_hold;
    s.bvalid && !s_axi_bready |=> s.bvalid && $stable(s.bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");

  property p_write_resp;
    s.aw_have && s.w_have && !s.bvalid |=> s.bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");

  property p_err_clear;
    err_rst && cause_present == '0 && node_fault == '0 && !fb_evt.valid && !tmo_pulse
      |=> s.flags == '0 && s.nodes == '0 && !s.halt_all;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error reset left flags set");

  property p_keep_cause;
    err_rst && !fb_evt.valid && !tmo_pulse
      |=> s.flags[NUM_CAUSE-1:0] == ($past(s.flags[NUM_CAUSE-1:0]) & $past(cause_present));
  endproperty
  a_keep_cause: assert property (p_keep_cause) else $error("cause flags wrong after reset");

  property p_irq_clear;
    rd_stat && !fb_evt.valid && !tmo_pulse |=> s.irq_stat == '0 && !s.irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status read did not clear");

  property p_rvalid_hold;
    s.rvalid && !s_axi_rready |=> s.rvalid && $stable(s.rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped early");

  property p_stop_no_node;
    fb_evt.valid && s.ctrl[CTRL_STOP_BIT] && !err_rst |=> s.halt_node == $past(s.halt_node);
  endproperty
  a_stop_no_node: assert property (p_stop_no_node) else $error("stop mode halted one slave");

  c_fatal: cover property (fb_evt.valid && FATAL_KIND[fb_evt.cause] ##1 s.halt_all);
  c_nonfatal: cover property (fb_evt.valid && !FATAL_KIND[fb_evt.cause] ##1 s.flags[FLG_NONFATAL]);
  c_timeout: cover property (tmo_pulse ##1 s.irq);
  c_reset: cover property (s.flags[FLG_GENERAL] ##1 err_rst ##1 !s.flags[FLG_GENERAL]);
endmodule

/* File: fb_err_pkg.sv */
// Constants and types of the fieldbus error flag block
package fb_err_pkg;
  localparam int NODES = 80;
  localparam int NODE_W = 7;
  localparam int LOCAL_NODES = 16;
  localparam int NUM_CAUSE = 9;
  localparam int IRQ_W = 12;
  localparam int TO_W = 8;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_REMOTE_LO = 8'h10;
  localparam logic [7:0] ADDR_REMOTE_HI = 8'h14;
  localparam logic [7:0] ADDR_HALT = 8'h18;

  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  localparam int CTRL_TO_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0300;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_FF01;

  localparam int FLG_GENERAL = 9;
  localparam int FLG_NONFATAL = 10;
  localparam int FLG_FATAL = 11;
  localparam int FLG_LOCAL_LSB = 16;
  localparam int HALT_ALL_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    C_CFG, C_TOPO, C_TIMEOUT, C_PARAM, C_SEND, C_LINK, C_DUP, C_INIT, C_AL
  } cause_t;

  // Kinds that stop all slaves even in continue mode
  localparam logic [NUM_CAUSE-1:0] FATAL_KIND = 9'h05F;

  typedef struct packed {
    logic valid;
    cause_t cause;
    logic [NODE_W-1:0] node;
  } fb_evt_t;

  typedef struct packed {
    logic [TO_W-1:0] cnt;
    logic fired;
    logic pulse;
  } tmo_st_t;
endpackage

/* File: fb_rx_timeout.sv */
// Missed frame counter with timeout detection
module fb_rx_timeout
  import fb_err_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cycle_tick,
  input wire logic frame_ok,
  input wire logic [TO_W-1:0] limit,
  output logic timeout
);
  tmo_st_t s;
  tmo_st_t n;

  always_comb begin
    n = s;
    n.pulse = 1'b0;
    if (cycle_tick) begin
      if (frame_ok) begin
        n.cnt = '0;
        n.fired = 1'b0;
      end else begin
        if (s.cnt != {TO_W{1'b1}}) begin
          n.cnt = s.cnt + 8'h01;
        end
        if (n.cnt > limit && !s.fired) begin
          n.pulse = 1'b1;
          n.fired = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign timeout = s.pulse;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_tmo_once;
    s.pulse |=> !s.pulse;
  endproperty
  a_tmo_once: assert property (p_tmo_once) else $error("timeout pulse longer than one cycle");

  property p_tmo_reset;
    cycle_tick && frame_ok |=> s.cnt == 8'h00 && !s.pulse;
  endproperty
  a_tmo_reset: assert property (p_tmo_reset) else $error("received frame did not reset count");
endmodule

/* File: fb_slave_model.sv */
// Behavioural model of the fieldbus slave nodes
module fb_slave_model
  import fb_err_pkg::*;
(
  input wire logic clk_sys,
  output fb_evt_t fb_evt,
  output logic cycle_tick,
  output logic frame_ok,
  output logic [NUM_CAUSE-1:0] cause_present,
  output logic [NODES-1:0] node_fault
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    fb_evt = '0;
    cycle_tick = 1'b0;
    frame_ok = 1'b0;
    cause_present = '0;
    node_fault = '0;
  end

  // One-cycle error event at a node
  task automatic raise(input cause_t c, input logic [NODE_W-1:0] n);
    @(posedge clk_sys);
    fb_evt <= '{valid: 1'b1, cause: c, node: n};
    @(posedge clk_sys);
    fb_evt <= '0;
  endtask

  // One communication cycle, frame received or lost
  task automatic cycle(input logic ok);
    @(posedge clk_sys);
    cycle_tick <= 1'b1;
    frame_ok <= ok;
    @(posedge clk_sys);
    cycle_tick <= 1'b0;
    frame_ok <= ~ok;
    repeat (3) @(posedge clk_sys);
  endtask

  // Causes and faulty nodes still present
  task automatic hold(input logic [NUM_CAUSE-1:0] c, input logic [NODES-1:0] n);
    @(posedge clk_sys);
    cause_present <= c;
    node_fault <= n;
  endtask
endmodule

/* File: testbench.sv */
// Self-checking bench of the fieldbus error flag block
module testbench
  import fb_err_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, awready, wready, bvalid, arready, rvalid, halt_all, irq;
  logic awvalid, wvalid, bready, arvalid, rready, cycle_tick, frame_ok;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  fb_evt_t fb_evt;
  logic [NUM_CAUSE-1:0] cause_present;
  logic [NODES-1:0] node_fault, halt_node;
  int num_errors, checked;

  fb_err_flags i_fb_err_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .fb_evt(fb_evt),
    .cycle_tick(cycle_tick),
    .frame_ok(frame_ok),
    .cause_present(cause_present),
    .node_fault(node_fault),
    .halt_all(halt_all),
    .halt_node(halt_node),
    .irq(irq)
  );

  fb_slave_model i_fb_slave_model (
    .clk_sys(clk_sys),
    .fb_evt(fb_evt),
    .cycle_tick(cycle_tick),
    .frame_ok(frame_ok),
    .cause_present(cause_present),
    .node_fault(node_fault)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string n, input logic [79:0] s, input logic [79:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    output logic [1:0] rs);
    logic da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk_sys);
      if (awready) da = 1'b1;
      if (wready) dw = 1'b1;
      @(posedge clk_sys);
      if (da) awvalid <= 1'b0;
      if (dw) wvalid <= 1'b0;
    end
    do @(negedge clk_sys); while (!bvalid);
    rs = bresp;
    @(posedge clk_sys);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk_sys); while (!arready);
    @(posedge clk_sys);
    arvalid <= 1'b0;
    do @(negedge clk_sys); while (!rvalid);
    v = rdata;
    rs = rresp;
    @(posedge clk_sys);
    rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk(n, 80'(v), 80'(e));
  endtask

  // Error reset with the given control value
  task automatic er(input logic [31:0] c);
    wr(ADDR_CTRL, c | 32'h0000_0002, 4'hF, r);
  endtask

  function automatic logic [31:0] fl(input int c, input logic fat, input int n);
    fl = (32'h1 << c) | 32'h0000_0200 | (fat ? 32'h0000_0800 : 32'h0000_0400);
    if (n >= 1 && n <= 16) fl = fl | (32'h1 << (15 + n));
  endfunction

  task automatic t_reset();
    rdchk(ADDR_CTRL, 32'h0000_0300, "ctrl reset");
    rdchk(ADDR_IRQ_MASK, 32'h0, "mask reset");
    chk("halt_all reset", 80'(halt_all), 80'h0);
  endtask

  task automatic t_causes();
    for (int c = 0; c < NUM_CAUSE; c++) begin
      er(32'h0000_0300);
      i_fb_slave_model.raise(cause_t'(c), 7'h03);
      rdchk(ADDR_FLAGS, fl(c, FATAL_KIND[c], 3), "flags");
      chk("halt_all", 80'(halt_all), 80'(FATAL_KIND[c]));
      chk("halt_node", halt_node, FATAL_KIND[c] ? 80'h0 : 80'h4);
    end
  endtask

  task automatic t_nodes();
    er(32'h0000_0300);
    i_fb_slave_model.raise(C_INIT, 7'd17);
    i_fb_slave_model.raise(C_AL, 7'd80);
    i_fb_slave_model.raise(C_LINK, 7'd16);
    rdchk(ADDR_REMOTE_LO, 32'h0000_0001, "remote lo");
    rdchk(ADDR_REMOTE_HI, 32'h8000_0000, "remote hi");
    rdchk(ADDR_FLAGS, 32'h8000_07A0, "local nodes");
    chk("halt_node", halt_node, 80'h8000_0000_0000_0001_8000);
  endtask

  task automatic t_stop();
    er(32'h0000_0301);
    i_fb_slave_model.raise(C_AL, 7'd5);
    rdchk(ADDR_FLAGS, fl(8, 1'b1, 5), "stop flags");
    chk("stop halt_all", 80'(halt_all), 80'h1);
    rdchk(ADDR_HALT, 32'h0000_0001, "halt reg");
  endtask

  task automatic t_hold();
    er(32'h0000_0300);
    i_fb_slave_model.raise(C_LINK, 7'd5);
    i_fb_slave_model.hold(9'h020, 80'h10);
    er(32'h0000_0300);
    rdchk(ADDR_FLAGS, fl(5, 1'b0, 5), "kept flags");
    chk("kept halt_node", halt_node, 80'h10);
    i_fb_slave_model.hold(9'h000, 80'h0);
    er(32'h0000_0300);
    rdchk(ADDR_FLAGS, 32'h0, "cleared flags");
    chk("cleared halt_node", halt_node, 80'h0);
  endtask

  task automatic t_bus();
    rd(8'h1C, d, r);
    chk("unmapped rresp", 80'(r), 80'(RESP_SLVERR));
    chk("unmapped rdata", 80'(d), 80'h0);
    wr(8'h20, 32'hFFFF_FFFF, 4'hF, r);
    chk("unmapped bresp", 80'(r), 80'(RESP_SLVERR));
    wr(ADDR_FLAGS, 32'hFFFF_FFFF, 4'hF, r);
    chk("ro bresp", 80'(r), 80'(RESP_OKAY));
    rdchk(ADDR_FLAGS, 32'h0, "ro flags");
  endtask

  task automatic t_timeout();
    wr(ADDR_CTRL, 32'h0000_0201, 4'h2, r);
    rdchk(ADDR_CTRL, 32'h0000_0200, "ctrl lane");
    repeat (2) i_fb_slave_model.cycle(1'b0);
    rdchk(ADDR_FLAGS, 32'h0, "no timeout");
    i_fb_slave_model.cycle(1'b0);
    rdchk(ADDR_FLAGS, fl(2, 1'b1, 0), "timeout");
    er(32'h0000_0200);
    i_fb_slave_model.cycle(1'b1);
    repeat (2) i_fb_slave_model.cycle(1'b0);
    rdchk(ADDR_FLAGS, 32'h0, "rearm no timeout");
    i_fb_slave_model.cycle(1'b0);
    rdchk(ADDR_FLAGS, fl(2, 1'b1, 0), "rearm timeout");
  endtask

  task automatic t_irq();
    rd(ADDR_IRQ_STAT, d, r);
    er(32'h0000_0300);
    i_fb_slave_model.raise(C_LINK, 7'd2);
    @(negedge clk_sys);
    chk("irq masked", 80'(irq), 80'h0);
    wr(ADDR_IRQ_MASK, 32'h0000_0400, 4'hF, r);
    @(negedge clk_sys);
    chk("irq raised", 80'(irq), 80'h1);
    rdchk(ADDR_IRQ_STAT, fl(5, 1'b0, 2) & 32'h0000_0FFF, "irq stat");
    @(negedge clk_sys);
    chk("irq cleared", 80'(irq), 80'h0);
    rdchk(ADDR_IRQ_STAT, 32'h0, "stat cleared");
  endtask

  task automatic test_done();
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_causes();
    t_nodes();
    t_stop();
    t_hold();
    t_bus();
    t_timeout();
    t_irq();
    test_done();
  end
endmodule
